// ---- src/crosspoint_profile_switch.sv ----
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "xps_cfg.svh"
// Contract
// - two profiles per output, primary by default
// - reset and reset pin give identity
// - switch event routes from secondary profile
// - software bit one applies secondary profile
// - pin high with enable selects secondary
// - each pin level change moves profile while pin enabled
// - three-bit fields hold binary input index
// - pin enable: pin selects, software ignored
// - pin disabled: software bit selects profile
module crosspoint_profile_switch (
   input  wire logic                sys_clk,            // register clock, 10 MHz
   input  wire logic                arst_n,             // async reset, low active
   input  wire logic                link_clk,           // link clock
   input  wire logic [`ADDR_W-1:0]  paddr,              // apb address
   input  wire logic                psel,               // apb select
   input  wire logic                penable,            // apb enable
   input  wire logic                pwrite,             // apb direction
   input  wire logic [`DATA_W-1:0]  pwdata,             // apb write data
   output logic      [`DATA_W-1:0]  prdata,             // apb read data
   output logic                     pready,             // apb ready
   output logic                     pslverr,            // apb error, unmapped
   input  wire logic                config_reset_pin_n, // config clear pin, low
   input  wire logic                switch_trigger_pin, // switch pin
   output xps_pkg::route_t          routeSel,           // input index per output
   output logic                     activeSecondary     // secondary in use
);
   import xps_pkg::*;

   // three-bit source field of a bus word
   function automatic sel_t selField(input logic [`DATA_W-1:0] word, input int lsb);
      return word[lsb +: `SEL_W];
   endfunction

   cfg_link_if lnk();

   logic         rstMeta_q, rstN_q, rstMeta_d, rstN_d;
   logic         cfgMeta_q, cfgSync_q, cfgClear;
   logic         cfgMeta_d, cfgSync_d;
   logic         ackMeta_q, ackSync_q, actMeta_q, actSync_q;
   logic         ackMeta_d, ackSync_d, actMeta_d, actSync_d;
   route_t       pri_q, pri_d, sec_q, sec_d;
   logic         pinEn_q, pinEn_d, swSel_q, swSel_d;
   route_t       txPri_q, txPri_d, txSec_q, txSec_d;
   logic         txPinEn_q, txPinEn_d, txSwSel_q, txSwSel_d;
   logic         req_q, req_d;
   hs_state_e    hsState_q, hsState_d;
   logic [`DATA_W-1:0] prdata_q, prdata_d;
   reg_kind_e    kind;
   logic [`SEL_W-1:0] portIdx;
   logic         access, wrEn, setup, cfgDiff;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end else begin
         rstMeta_q <= rstMeta_d;
         rstN_q    <= rstN_d;
      end
   end

   always_comb begin
      rstMeta_d = 1'b1;
      rstN_d    = rstMeta_q;
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         cfgMeta_q <= 1'b1;
         cfgSync_q <= 1'b1;
         ackMeta_q <= 1'b0;
         ackSync_q <= 1'b0;
         actMeta_q <= 1'b0;
         actSync_q <= 1'b0;
      end else begin
         cfgMeta_q <= cfgMeta_d;
         cfgSync_q <= cfgSync_d;
         ackMeta_q <= ackMeta_d;
         ackSync_q <= ackSync_d;
         actMeta_q <= actMeta_d;
         actSync_q <= actSync_d;
      end
   end

   always_comb begin
      cfgMeta_d = config_reset_pin_n;
      cfgSync_d = cfgMeta_q;
      ackMeta_d = lnk.ack;
      ackSync_d = ackMeta_q;
      actMeta_d = lnk.activeSec;
      actSync_d = actMeta_q;
   end

   assign cfgClear = !cfgSync_q;
   assign kind     = decodeKind(paddr);
   assign portIdx  = paddr[`IDX_LSB +: `SEL_W];
   assign setup    = psel && !penable;
   assign access   = psel && penable;
   assign wrEn     = access && pwrite && !cfgClear;
   assign pready   = access;
   assign pslverr  = access && (kind == REG_NONE);
   assign prdata   = prdata_q;

   // configuration registers
   always_comb begin
      pri_d   = pri_q;
      sec_d   = sec_q;
      pinEn_d = pinEn_q;
      swSel_d = swSel_q;
      if (cfgClear) begin
         pri_d   = `IDENTITY;
         sec_d   = `IDENTITY;
         pinEn_d = 1'b0;
         swSel_d = 1'b0;
      end else if (wrEn) begin
         case (kind)
            REG_PRI: begin
               pri_d[portIdx] = selField(pwdata, `PRI_LSB);
            end
            REG_SEC: begin
               sec_d[portIdx] = selField(pwdata, `SEC_LSB);
            end
            REG_SWCTL: begin
               pinEn_d = pwdata[`PINEN_BIT];
               swSel_d = pwdata[`SWSEL_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         pri_q   <= `IDENTITY;
         sec_q   <= `IDENTITY;
         pinEn_q <= 1'b0;
         swSel_q <= 1'b0;
      end else begin
         pri_q   <= pri_d;
         sec_q   <= sec_d;
         pinEn_q <= pinEn_d;
         swSel_q <= swSel_d;
      end
   end

   // read data captured in the setup cycle, stable through access
   always_comb begin
      prdata_d = prdata_q;
      if (setup) begin
         prdata_d = '0;
         case (kind)
            REG_PRI: prdata_d[`PRI_LSB +: `SEL_W] = pri_q[portIdx];
            REG_SEC: prdata_d[`SEC_LSB +: `SEL_W] = sec_q[portIdx];
            REG_SWCTL: begin
               prdata_d[`PINEN_BIT] = pinEn_q;
               prdata_d[`SWSEL_BIT] = swSel_q;
            end
            REG_STATUS: begin
               prdata_d[`ST_ACT_BIT]  = actSync_q;
               prdata_d[`ST_BUSY_BIT] = (hsState_q == HS_WAIT);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) prdata_q <= '0;
      else prdata_q <= prdata_d;
   end

   // toggle handshake carries one complete snapshot to the link side
   assign cfgDiff = (pri_q != txPri_q) || (sec_q != txSec_q) ||
                    (pinEn_q != txPinEn_q) || (swSel_q != txSwSel_q);

   always_comb begin
      hsState_d = hsState_q;
      req_d     = req_q;
      txPri_d   = txPri_q;
      txSec_d   = txSec_q;
      txPinEn_d = txPinEn_q;
      txSwSel_d = txSwSel_q;
      case (hsState_q)
         HS_IDLE: begin
            if (cfgDiff) begin
               txPri_d   = pri_q;
               txSec_d   = sec_q;
               txPinEn_d = pinEn_q;
               txSwSel_d = swSel_q;
               req_d     = !req_q;
               hsState_d = HS_WAIT;
            end
         end
         HS_WAIT: begin
            if (ackSync_q == req_q) hsState_d = HS_IDLE;
         end
         default: hsState_d = HS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstN_q) begin
      if (!rstN_q) begin
         hsState_q <= HS_IDLE;
         req_q     <= 1'b0;
         txPri_q   <= `IDENTITY;
         txSec_q   <= `IDENTITY;
         txPinEn_q <= 1'b0;
         txSwSel_q <= 1'b0;
      end else begin
         hsState_q <= hsState_d;
         req_q     <= req_d;
         txPri_q   <= txPri_d;
         txSec_q   <= txSec_d;
         txPinEn_q <= txPinEn_d;
         txSwSel_q <= txSwSel_d;
      end
   end

   assign lnk.req   = req_q;
   assign lnk.pri   = txPri_q;
   assign lnk.sec   = txSec_q;
   assign lnk.pinEn = txPinEn_q;
   assign lnk.swSel = txSwSel_q;

   link_route u_link (
      .linkClk            (link_clk),
      .arst_n             (arst_n),
      .switch_trigger_pin (switch_trigger_pin),
      .lnk                (lnk.linkSide),
      .routeSel           (routeSel),
      .activeSecondary    (activeSecondary)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstN_q);

   clearIdentity_a: assert property (
      cfgClear |=> pri_q == `IDENTITY && sec_q == `IDENTITY && !pinEn_q && !swSel_q)
      else $error("config clear did not restore identity");
   priWrite_a: assert property (
      wrEn && kind == REG_PRI |=> pri_q[$past(portIdx)] == $past(pwdata[`PRI_LSB +: `SEL_W]))
      else $error("primary field write lost");
   hsDeliver_a: assert property (
      $changed(req_q) |-> ##[1:20] (ackSync_q == req_q))
      else $error("config snapshot not acknowledged");
   secWrite_a: assert property (
      wrEn && kind == REG_SEC |=> sec_q[$past(portIdx)] == $past(pwdata[`SEC_LSB +: `SEL_W]))
      else $error("secondary field write lost");
   ctlWrite_a: assert property (
      wrEn && kind == REG_SWCTL
      |=> {pinEn_q, swSel_q} == $past({pwdata[`PINEN_BIT], pwdata[`SWSEL_BIT]}))
      else $error("switch control write lost");
   cfgHold_a: assert property (
      !wrEn && !cfgClear |=> $stable({pri_q, sec_q, pinEn_q, swSel_q}))
      else $error("configuration changed without write");
   priOnly_a: assert property (
      wrEn && kind == REG_PRI |=> $stable({sec_q, pinEn_q, swSel_q}))
      else $error("primary write disturbed other fields");

   // snapshot handed to the link side, and read data
   snapTake_a: assert property (
      hsState_q == HS_IDLE && cfgDiff |=> {txPri_q, txSec_q} == $past({pri_q, sec_q}))
      else $error("snapshot not taken whole");
   snapHold_a: assert property (
      hsState_q == HS_WAIT |=> $stable({txPri_q, txSec_q, txPinEn_q, txSwSel_q}))
      else $error("snapshot moved while in flight");
   reqToggle_a: assert property (
      $changed(req_q) |-> $past(hsState_q) == HS_IDLE && hsState_q == HS_WAIT)
      else $error("request toggled outside idle");
   hsDone_a: assert property (
      hsState_q == HS_WAIT && ackSync_q == req_q |=> hsState_q == HS_IDLE)
      else $error("handshake did not complete");
   idleQuiet_a: assert property (
      hsState_q == HS_IDLE && !cfgDiff |=> $stable(req_q))
      else $error("request sent with nothing new");
   readPri_a: assert property (
      setup && kind == REG_PRI |=> prdata[`PRI_LSB +: `SEL_W] == $past(pri_q[portIdx]))
      else $error("primary field read wrong");
   readSec_a: assert property (
      setup && kind == REG_SEC |=> prdata[`SEC_LSB +: `SEL_W] == $past(sec_q[portIdx]))
      else $error("secondary field read wrong");
   readCtl_a: assert property (
      setup && kind == REG_SWCTL
      |=> {prdata[`PINEN_BIT], prdata[`SWSEL_BIT]} == $past({pinEn_q, swSel_q}))
      else $error("switch control read wrong");
   statusAct_a: assert property (
      setup && kind == REG_STATUS |=> prdata[`ST_ACT_BIT] == $past(actSync_q))
      else $error("status active bit wrong");
   statusBusy_a: assert property (
      setup && kind == REG_STATUS |=> prdata[`ST_BUSY_BIT] == $past(hsState_q == HS_WAIT))
      else $error("status busy bit wrong");

   clearPin_c: cover property ($fell(cfgSync_q) ##1 cfgClear);
   swWrite_c:  cover property (wrEn && kind == REG_SWCTL && pwdata[`SWSEL_BIT]);
   hsDone_c:   cover property (hsState_q == HS_WAIT ##[1:20] hsState_q == HS_IDLE);
endmodule
`default_nettype wire

// ---- src/xps_cfg.svh ----
`ifndef XPS_CFG_SVH
`define XPS_CFG_SVH

`define NUM_PORTS    8
`define SEL_W        3
`define ADDR_W       12
`define DATA_W       32
`define IDENTITY     24'hFAC688
`define PROFILE_MASK 12'hFE0
`define IDX_LSB      2
`define OFF_PRI_BASE 12'h000
`define OFF_SEC_BASE 12'h020
`define OFF_SWCTL    12'h040
`define OFF_STATUS   12'h044
`define PRI_LSB      5
`define SEC_LSB      4
`define PINEN_BIT    7
`define SWSEL_BIT    6
`define ST_ACT_BIT   0
`define ST_BUSY_BIT  1

`endif

// ---- src/xps_pkg.sv ----
`default_nettype none
`include "xps_cfg.svh"
package xps_pkg;
   typedef logic [`SEL_W-1:0] sel_t;
   typedef logic [`NUM_PORTS-1:0][`SEL_W-1:0] route_t;
   typedef enum {REG_PRI, REG_SEC, REG_SWCTL, REG_STATUS, REG_NONE} reg_kind_e;
   typedef enum {HS_IDLE, HS_WAIT} hs_state_e;

   function automatic reg_kind_e decodeKind(input logic [`ADDR_W-1:0] addr);
      reg_kind_e kind;
      kind = REG_NONE;
      if (addr[1:0] == 2'h0) begin
         if ((addr & `PROFILE_MASK) == `OFF_PRI_BASE) kind = REG_PRI;
         else if ((addr & `PROFILE_MASK) == `OFF_SEC_BASE) kind = REG_SEC;
         else if (addr == `OFF_SWCTL) kind = REG_SWCTL;
         else if (addr == `OFF_STATUS) kind = REG_STATUS;
      end
      return kind;
   endfunction
endpackage
`default_nettype wire

// ---- src/cfg_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
   import xps_pkg::*;
   logic   req;
   logic   ack;
   route_t pri;
   route_t sec;
   logic   pinEn;
   logic   swSel;
   logic   activeSec;
   modport cfgSide  (output req, pri, sec, pinEn, swSel, input ack, activeSec);
   modport linkSide (input req, pri, sec, pinEn, swSel, output ack, activeSec);
endinterface
`default_nettype wire

// ---- src/link_route.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xps_cfg.svh"
module link_route (
   input  wire logic             linkClk,            // link-side clock
   input  wire logic             arst_n,             // async reset, low active
   input  wire logic             switch_trigger_pin, // raw switch pin
   cfg_link_if.linkSide          lnk,                // config from register side
   output xps_pkg::route_t       routeSel,           // input index per output
   output logic                  activeSecondary     // secondary profile in use
);
   import xps_pkg::*;

   logic   linkMeta_q, linkRstN_q;
   logic   pinMeta_q, pinSync_q, reqMeta_q, reqSync_q;
   logic   reqSeen_q, reqSeen_d;
   route_t curPri_q, curPri_d, curSec_q, curSec_d, routeSel_q, routeSel_d;
   logic   curPinEn_q, curPinEn_d, curSwSel_q, curSwSel_d;
   logic   activeSec_q, activeSec_d, useSec;

   always_ff @(posedge linkClk or negedge arst_n) begin
      if (!arst_n) begin
         linkMeta_q <= 1'b0;
         linkRstN_q <= 1'b0;
      end else begin
         linkMeta_q <= 1'b1;
         linkRstN_q <= linkMeta_q;
      end
   end

   always_ff @(posedge linkClk or negedge linkRstN_q) begin
      if (!linkRstN_q) begin
         pinMeta_q <= 1'b0;
         pinSync_q <= 1'b0;
         reqMeta_q <= 1'b0;
         reqSync_q <= 1'b0;
      end else begin
         pinMeta_q <= switch_trigger_pin;
         pinSync_q <= pinMeta_q;
         reqMeta_q <= lnk.req;
         reqSync_q <= reqMeta_q;
      end
   end

   // profile choice: pin when enabled, else software bit
   assign useSec = curPinEn_q ? pinSync_q : curSwSel_q;

   always_comb begin
      reqSeen_d  = reqSeen_q;
      curPri_d   = curPri_q;
      curSec_d   = curSec_q;
      curPinEn_d = curPinEn_q;
      curSwSel_d = curSwSel_q;
      if (reqSync_q != reqSeen_q) begin
         reqSeen_d  = reqSync_q;
         curPri_d   = lnk.pri;
         curSec_d   = lnk.sec;
         curPinEn_d = lnk.pinEn;
         curSwSel_d = lnk.swSel;
      end
      activeSec_d = useSec;
      // all eight selections taken from one profile in one edge
      routeSel_d = useSec ? curSec_q : curPri_q;
   end

   always_ff @(posedge linkClk or negedge linkRstN_q) begin
      if (!linkRstN_q) begin
         reqSeen_q   <= 1'b0;
         curPri_q    <= `IDENTITY;
         curSec_q    <= `IDENTITY;
         curPinEn_q  <= 1'b0;
         curSwSel_q  <= 1'b0;
         routeSel_q  <= `IDENTITY;
         activeSec_q <= 1'b0;
      end else begin
         reqSeen_q   <= reqSeen_d;
         curPri_q    <= curPri_d;
         curSec_q    <= curSec_d;
         curPinEn_q  <= curPinEn_d;
         curSwSel_q  <= curSwSel_d;
         routeSel_q  <= routeSel_d;
         activeSec_q <= activeSec_d;
      end
   end

   assign lnk.ack         = reqSeen_q;
   assign lnk.activeSec   = activeSec_q;
   assign routeSel        = routeSel_q;
   assign activeSecondary = activeSec_q;

   default clocking cb @(posedge linkClk); endclocking
   default disable iff (!linkRstN_q);

   primRoute_a: assert property (!useSec |=> routeSel_q == $past(curPri_q))
      else $error("primary profile not routed");
   secRoute_a: assert property (useSec |=> routeSel_q == $past(curSec_q))
      else $error("secondary profile not routed");
   pinFollow_a: assert property (
      curPinEn_q && $changed(pinSync_q) |=> activeSec_q == $past(pinSync_q))
      else $error("pin change did not move profile");
   pinHigh_a: assert property (
      (curPinEn_q && pinSync_q) [*2] |-> activeSec_q && routeSel_q == $past(curSec_q))
      else $error("high pin did not select secondary");
   swIgnored_a: assert property (
      curPinEn_q && $stable(curPinEn_q) && $stable(pinSync_q) && $changed(curSwSel_q)
      |=> $stable(activeSec_q))
      else $error("software bit acted while pin enabled");
   swSelect_a: assert property (!curPinEn_q |=> activeSec_q == $past(curSwSel_q))
      else $error("software bit did not select profile");
   allTogether_a: assert property (
      (useSec && $stable(curSec_q)) [*2] |-> routeSel_q == curSec_q)
      else $error("outputs on mixed profile");

   pinSwitch_c: cover property (curPinEn_q && $rose(pinSync_q) ##1 activeSec_q);
   swSwitch_c:  cover property (!curPinEn_q && $rose(curSwSel_q) ##1 activeSec_q);
endmodule
`default_nettype wire

// ---- dv/host_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_pins (
   input  wire logic sys_clk,            // controller clock
   input  wire logic arst_n,             // power-on reset, low active
   input  wire logic swReq,              // requested switch level
   input  wire logic clrReq,             // requested config clear
   output logic      switch_trigger_pin, // fast switch pin
   output logic      config_reset_pin_n  // config clear pin, low active
);
   logic swPin_d;
   logic cfgRstN_d;

   // pin path used where a bus write would be too slow
   always_comb begin
      swPin_d   = swReq;
      cfgRstN_d = !clrReq;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         switch_trigger_pin <= 1'h0;
         config_reset_pin_n <= 1'h0; // device held in reset at power-up
      end else begin
         switch_trigger_pin <= swPin_d;
         config_reset_pin_n <= cfgRstN_d;
      end
   end
endmodule
`default_nettype wire

// ---- dv/test_crosspoint_profile_switch.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xps_cfg.svh"
module test_crosspoint_profile_switch;
   import xps_pkg::*;
   logic               sys_clk;
   logic               link_clk;
   logic               arst_n;
   logic [`ADDR_W-1:0] paddr;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [`DATA_W-1:0] pwdata;
   logic [`DATA_W-1:0] prdata;
   logic               pready;
   logic               pslverr;
   logic               swPin;
   logic               cfgRstN;
   logic               swReq;
   logic               clrReq;
   route_t             routeSel;
   logic               activeSecondary;
   route_t             priR;
   route_t             secR;
   logic [31:0]        rd;
   logic               err;
   int                 fail_count;
   int                 n_tests;

   crosspoint_profile_switch dut (.sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .config_reset_pin_n(cfgRstN),
      .switch_trigger_pin(swPin), .routeSel(routeSel), .activeSecondary(activeSecondary));

   host_pins host (.sys_clk(sys_clk), .arst_n(arst_n), .swReq(swReq), .clrReq(clrReq),
      .switch_trigger_pin(swPin), .config_reset_pin_n(cfgRstN));

   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = !sys_clk;
   end

   initial begin
      link_clk = 1'h0;
      #11;
      forever #32 link_clk = !link_clk;
   end

   task automatic close_out();
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         $display("[FAIL] %0t apb no ready", $time);
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic waitRoute(input route_t exp, input logic sec);
      int n;
      n = 0;
      while ((routeSel !== exp || activeSecondary !== sec) && n < 30) begin
         @(posedge sys_clk);
         n++;
      end
      chkWord(32'(routeSel), 32'(exp), "route");
      chkWord({31'h0, activeSecondary}, {31'h0, sec}, "active");
      if (n >= 30) begin
         fail_count++;
         $display("[FAIL] %0t route wait timed out", $time);
         close_out();
      end
   endtask

   function automatic route_t mk(input int b, input int s);
      route_t r;
      for (int i = 0; i < `NUM_PORTS; i++) begin
         r[i] = sel_t'((b + s * i) % 8);
      end
      return r;
   endfunction

   initial begin
      arst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      swReq = 1'h0;
      clrReq = 1'h0;
      fail_count = 0;
      n_tests = 0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'h1; // reset released after power-up
      repeat (4) @(posedge sys_clk);
      waitRoute(mk(0, 1), 1'h0);
      for (int i = 0; i < `NUM_PORTS; i++) begin
         apb(1'h0, `ADDR_W'(`OFF_PRI_BASE + 4 * i), 32'h0);
         chkWord(rd, 32'(i) << `PRI_LSB, "pri reset");
         apb(1'h0, `ADDR_W'(`OFF_SEC_BASE + 4 * i), 32'h0);
         chkWord(rd, 32'(i) << `SEC_LSB, "sec reset");
      end
      apb(1'h0, `OFF_SWCTL, 32'h0);
      chkWord(rd, 32'h0, "ctl reset");
      $display("test reset done");
      priR = mk(7, 7);
      secR = mk(3, 1);
      for (int i = 0; i < `NUM_PORTS; i++) begin
         apb(1'h1, `ADDR_W'(`OFF_PRI_BASE + 4 * i), 32'(priR[i]) << `PRI_LSB);
         apb(1'h1, `ADDR_W'(`OFF_SEC_BASE + 4 * i), 32'(secR[i]) << `SEC_LSB);
      end
      waitRoute(priR, 1'h0);
      $display("test profiles done");
      apb(1'h1, `OFF_SWCTL, 32'h1 << `SWSEL_BIT);
      waitRoute(secR, 1'h1);
      apb(1'h0, `OFF_STATUS, 32'h0);
      chkWord(rd & 32'h1, 32'h1, "status");
      apb(1'h1, `OFF_SWCTL, 32'h0);
      waitRoute(priR, 1'h0);
      $display("test software switch done");
      apb(1'h1, `OFF_SWCTL, (32'h1 << `PINEN_BIT) | (32'h1 << `SWSEL_BIT));
      // let the snapshot land before judging
      repeat (12) @(posedge sys_clk);
      waitRoute(priR, 1'h0);
      swReq <= 1'h1;
      waitRoute(secR, 1'h1);
      swReq <= 1'h0;
      waitRoute(priR, 1'h0);
      swReq <= 1'h1;
      waitRoute(secR, 1'h1);
      apb(1'h1, `OFF_SWCTL, 32'h1 << `PINEN_BIT);
      repeat (12) @(posedge sys_clk);
      waitRoute(secR, 1'h1);
      apb(1'h1, `OFF_SWCTL, 32'h0);
      waitRoute(priR, 1'h0);
      swReq <= 1'h0;
      $display("test pin switch done");
      apb(1'h0, 12'h100, 32'h0);
      chkWord(rd, 32'h0, "unmapped data");
      chkWord({31'h0, err}, 32'h1, "unmapped err");
      clrReq <= 1'h1;
      waitRoute(mk(0, 1), 1'h0);
      apb(1'h1, `ADDR_W'(`OFF_PRI_BASE + 12), 32'h7 << `PRI_LSB);
      apb(1'h0, `ADDR_W'(`OFF_PRI_BASE + 12), 32'h0);
      chkWord(rd, 32'h3 << `PRI_LSB, "cleared pri");
      clrReq <= 1'h0;
      $display("test clear pin done");
      close_out();
   end
endmodule
`default_nettype wire
